// ===== verilog/ures_top.sv
// Operation
// - bad parity sets sticky parity flag
// - stop bit sampled zero sets framing flag
// - receiver checks one stop bit only
// - complete character buffered, receive ready raised
// - unread character overwritten, overrun flag set
// - errors never stop receive or transmit
// - command bit four clears all error flags
// - sync transmit line high until initialised
// - sync transmit needs clear-to-send low, enable
// - bits shift on falling transmit clock edge
// - empty sync buffer sends sync fill characters
// - transmitter empty high until next CPU data write
// - sync fill armed after first data character
// - break bit forces continuous zero output
// - status receive ready, empty, sync bits mirror pins
// - status data-set-ready is inverted pin
// - status transmit ready means buffer empty
// - transmit ready pin needs empty, clear, enable
// - unused upper received bits read zero
// - data-set-ready sits in status bit seven
// - command bit zero is transmit enable
// - command bit six returns to reset state
`timescale 1ns/1ps
`default_nettype none

// transmit shifter running on the link clock
module ures_tx_link
    import ures_pkg::*;
(
    input wire logic tx_bit_clock,
    input wire logic rstn,
    input wire logic [CFG_W-1:0] cfg,
    input wire logic req,
    input wire logic [7:0] tx_data,
    input wire logic clear_to_send_n,
    output logic ack,
    output logic busy,
    output logic txd
);
    ures_link_s s; // registered link state
    ures_link_s n; // next link state
    logic rst_n_m; // reset release, first stage
    logic rst_n_s; // reset release, second stage
    logic run; // initialisation complete
    logic go; // transmission allowed
    logic sync_mode; // synchronous framing selected
    logic [7:0] mode; // mode byte in link domain
    logic [5:0] reload; // link clocks per bit minus one
    logic [15:0] frm; // length and bits of next character

    // frame one character: length in the top nibble, bits lsb first
    function automatic logic [15:0] build(input logic [7:0] d, input logic [7:0] m);
        logic [FRAME_W-1:0] f;
        int pos;
        int len;
        logic par;
        f = 12'hFFF;
        pos = 0;
        len = int'(m[MODE_LEN_LSB+:2]) + int'(LEN_BASE);
        par = ~m[MODE_PARITY_EVEN];
        // async characters open with a start bit
        if (m[MODE_BAUD_LSB+:2] != BAUD_SYNC)
        begin
            f[0] = 1'b0;
            pos = 1;
        end
        for (int i = 0; i < 8; i++)
        begin
            if (i < len)
            begin
                f[pos+i] = d[i];
                par = par ^ d[i];
            end
        end
        pos = pos + len;
        // parity bit when enabled
        if (m[MODE_PARITY_ENABLE])
        begin
            f[pos] = par;
            pos = pos + 1;
        end
        // stop bits are already ones; 1.5 is sent as one
        if (m[MODE_BAUD_LSB+:2] != BAUD_SYNC)
        begin
            pos = pos + ((m[MODE_STOP_LSB+:2] == STOP_TWO) ? 2 : 1);
        end
        return {4'(pos), f};
    endfunction : build

    // reset release in the link domain
    always_ff @(negedge tx_bit_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_n_m <= 1'h0;
            rst_n_s <= 1'h0;
        end
        else
        begin
            rst_n_m <= 1'h1;
            rst_n_s <= rst_n_m;
        end
    end

    // next-state logic of the shifter
    always_comb
    begin
        n = s;
        n.cfg_m = cfg;
        n.cfg_s = s.cfg_m;
        n.req_m = req;
        n.req_s = s.req_m;
        n.cts_m = clear_to_send_n;
        n.cts_s = s.cts_m;
        run = s.cfg_s[CFG_RUN];
        mode = s.cfg_s[CFG_MODE_LSB+:8];
        sync_mode = (mode[MODE_BAUD_LSB+:2] == BAUD_SYNC);
        go = run & s.cfg_s[CFG_TX_ENABLE] & ~s.cts_s;
        frm = 16'h0000;
        // bit length in link clocks
        if (sync_mode || mode[MODE_BAUD_LSB+:2] == BAUD_X1)
        begin
            reload = DIV_X1;
        end
        else if (mode[MODE_BAUD_LSB+:2] == BAUD_X16)
        begin
            reload = DIV_X16;
        end
        else
        begin
            reload = DIV_X64;
        end
        if (s.div != 6'h00)
        begin
            n.div = s.div - 6'h01;
        end
        else
        begin
            n.div = reload;
            if (s.left != 4'h0)
            begin
                // next bit of the current character
                n.txd = s.sh[0];
                n.sh = {1'b1, s.sh[FRAME_W-1:1]};
                n.left = s.left - 4'h1;
            end
            else if (go && s.req_s != s.ack)
            begin
                // take the waiting data character
                frm = build(tx_data, mode);
                n.ack = ~s.ack;
                n.busy = 1'b1;
                n.armed = s.armed | sync_mode;
            end
            else if (go && sync_mode && s.armed)
            begin
                // filler when the buffer ran dry
                frm = build(s.sel2 ? s.cfg_s[CFG_SYNC2_LSB+:8] : s.cfg_s[CFG_SYNC1_LSB+:8], mode);
                n.sel2 = ~s.sel2 & ~mode[MODE_SINGLE_SYNC];
                n.busy = 1'b0;
            end
            else
            begin
                // idle line marks high
                n.busy = 1'b0;
                n.txd = 1'b1;
            end
            // first bit of a freshly loaded character
            if (frm[15:12] != 4'h0)
            begin
                n.txd = frm[0];
                n.sh = {1'b1, frm[FRAME_W-1:1]};
                n.left = frm[15:12] - 4'h1;
            end
        end
        // fill is disarmed until the next first character
        if (!run)
        begin
            n.armed = 1'b0;
            n.sel2 = 1'b0;
        end
        // break overrides whatever is being shifted
        if (run && s.cfg_s[CFG_BREAK])
        begin
            n.txd = 1'b0;
        end
    end

    // link state register, bits change on the falling clock edge
    always_ff @(negedge tx_bit_clock or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            s <= LINK_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    assign ack = s.ack;
    assign busy = s.busy;
    assign txd = s.txd;
endmodule : ures_tx_link

// CPU side, receiver and status of the controller
module ures_top
    import ures_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ctrl_data_sel,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic tx_bit_clock,
    output logic txd,
    input wire logic receive_bit_clock,
    input wire logic rxd,
    input wire logic clear_to_send_n,
    input wire logic data_set_ready_n,
    output logic request_to_send_n,
    output logic terminal_ready_n,
    output logic transmit_ready,
    output logic receive_ready,
    output logic transmitter_empty,
    output logic sync_detect
);
    ures_sys_s s; // registered state
    ures_sys_s n; // next state
    logic rst_n_m; // reset release, first stage
    logic rst_n_sync; // reset release, second stage
    logic link_ack; // handshake answer from link
    logic link_busy; // link shifting a data character
    logic [CFG_W-1:0] cfg; // settings for the link
    logic rd_act; // read strobe active
    logic wr_act; // write strobe active
    logic pend; // transmit word not yet taken
    logic rx_en; // receiver running
    logic [3:0] rx_len; // data bits per character
    logic [5:0] rx_div; // receive clocks per bit minus one
    logic [7:0] status; // status byte

    // reset release in the system domain
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_n_m <= 1'h0;
            rst_n_sync <= 1'h0;
        end
        else
        begin
            rst_n_m <= 1'h1;
            rst_n_sync <= rst_n_m;
        end
    end

    // settings crossing as quasi-static levels
    assign cfg = {s.run, s.cmd[CMD_TRANSMIT_ENABLE], s.cmd[CMD_SEND_BREAK], s.mode, s.sync1,
        s.sync2};

    // shifter on the transmit clock
    ures_tx_link u_link (
        .tx_bit_clock(tx_bit_clock),
        .rstn(rstn),
        .cfg(cfg),
        .req(s.req),
        .tx_data(s.tx_data),
        .clear_to_send_n(clear_to_send_n),
        .ack(link_ack),
        .busy(link_busy),
        .txd(txd)
    );

    // next-state logic
    always_comb
    begin
        n = s;
        // two-stage synchronisers for every outside input
        n.cs_m = cs_n;
        n.cs_s = s.cs_m;
        n.rd_m = rd_n;
        n.rd_s = s.rd_m;
        n.wr_m = wr_n;
        n.wr_s = s.wr_m;
        n.cd_m = ctrl_data_sel;
        n.cd_s = s.cd_m;
        n.din_m = data_in;
        n.din_s = s.din_m;
        n.cts_m = clear_to_send_n;
        n.cts_s = s.cts_m;
        n.dsr_m = data_set_ready_n;
        n.dsr_s = s.dsr_m;
        n.rxc_m = receive_bit_clock;
        n.rxc_s = s.rxc_m;
        n.rxc_p = s.rxc_s;
        n.rxd_m = rxd;
        n.rxd_s = s.rxd_m;
        n.ack_m = link_ack;
        n.ack_s = s.ack_m;
        n.ack_p = s.ack_s;
        n.busy_m = link_busy;
        n.busy_s = s.busy_m;
        rd_act = ~s.cs_s & ~s.rd_s;
        wr_act = ~s.cs_s & ~s.wr_s;
        n.rd_p = rd_act;
        n.wr_p = wr_act;
        pend = (s.req != s.ack_s);
        rx_len = LEN_BASE + {2'b00, s.mode[MODE_LEN_LSB+:2]};
        rx_en = s.run & s.cmd[CMD_RECEIVE_ENABLE] & (s.mode[MODE_BAUD_LSB+:2] != BAUD_SYNC);
        // receive bit length
        if (s.mode[MODE_BAUD_LSB+:2] == BAUD_X16)
        begin
            rx_div = DIV_X16;
        end
        else if (s.mode[MODE_BAUD_LSB+:2] == BAUD_X1)
        begin
            rx_div = DIV_X1;
        end
        else
        begin
            rx_div = DIV_X64;
        end
        // hold empty low after the link takes a data character until its busy flag arrives
        if (s.ack_s != s.ack_p && !s.busy_s)
        begin
            n.wait_busy = 1'b1;
        end
        else if (s.busy_s)
        begin
            n.wait_busy = 1'b0;
        end
        // latch write data while the strobe is low
        if (wr_act)
        begin
            n.wr_cd = s.cd_s;
            n.wr_data = s.din_s;
        end
        // write completes on the rising strobe
        if (!wr_act && s.wr_p)
        begin
            if (s.wr_cd)
            begin
                case (s.init)
                    IS_MODE:
                    begin
                        n.mode = s.wr_data;
                        n.init = (s.wr_data[MODE_BAUD_LSB+:2] == BAUD_SYNC) ? IS_SYNC1 : IS_CMD;
                    end
                    IS_SYNC1:
                    begin
                        n.sync1 = s.wr_data;
                        n.init = s.mode[MODE_SINGLE_SYNC] ? IS_CMD : IS_SYNC2;
                    end
                    IS_SYNC2:
                    begin
                        n.sync2 = s.wr_data;
                        n.init = IS_CMD;
                    end
                    default:
                    begin
                        if (s.wr_data[CMD_SOFT_RESET])
                        begin
                            // back to the reset state, mode needed again
                            n.init = IS_MODE;
                            n.run = 1'b0;
                            n.mode = SYS_RESET.mode;
                            n.cmd = SYS_RESET.cmd;
                            n.rx_st = RX_IDLE;
                            n.rx_ready = 1'b0;
                            n.parity_flag = 1'b0;
                            n.overrun_flag = 1'b0;
                            n.framing_fault = 1'b0;
                        end
                        else
                        begin
                            n.cmd = s.wr_data;
                            n.init = IS_RUN;
                            n.run = 1'b1;
                            if (s.wr_data[CMD_CLEAR_FAULT_FLAGS])
                            begin
                                n.parity_flag = 1'b0;
                                n.overrun_flag = 1'b0;
                                n.framing_fault = 1'b0;
                            end
                        end
                    end
                endcase
            end
            else if (!pend)
            begin
                // data into the empty transmit buffer; a write while full is ignored
                n.tx_data = s.wr_data;
                n.req = ~s.req;
            end
        end
        // reading the data byte clears receive ready
        if (rd_act && !s.rd_p && !s.cd_s)
        begin
            n.rx_ready = 1'b0;
        end
        // receiver, advanced on rising receive clock edges
        if (s.rxc_s && !s.rxc_p)
        begin
            case (s.rx_st)
                RX_IDLE:
                begin
                    if (rx_en && !s.rxd_s)
                    begin
                        n.rx_idx = 4'h0;
                        n.rx_shift = 8'h00;
                        n.rx_par = ~s.mode[MODE_PARITY_EVEN];
                        if (rx_div == DIV_X1)
                        begin
                            n.rx_st = RX_BITS;
                            n.rx_cnt = DIV_X1;
                        end
                        else
                        begin
                            n.rx_st = RX_START;
                            n.rx_cnt = (rx_div == DIV_X16) ? HALF_X16 : HALF_X64;
                        end
                    end
                end
                RX_START:
                begin
                    if (s.rx_cnt != 6'h00)
                    begin
                        n.rx_cnt = s.rx_cnt - 6'h01;
                    end
                    else
                    begin
                        // confirm start bit at its middle
                        n.rx_st = s.rxd_s ? RX_IDLE : RX_BITS;
                        n.rx_cnt = rx_div;
                    end
                end
                default:
                begin
                    if (s.rx_cnt != 6'h00)
                    begin
                        n.rx_cnt = s.rx_cnt - 6'h01;
                    end
                    else
                    begin
                        n.rx_cnt = rx_div;
                        if (s.rx_idx < rx_len)
                        begin
                            // data bit, lsb first
                            n.rx_shift[s.rx_idx[2:0]] = s.rxd_s;
                            n.rx_par = s.rx_par ^ s.rxd_s;
                            n.rx_idx = s.rx_idx + 4'h1;
                        end
                        else if (s.mode[MODE_PARITY_ENABLE] && s.rx_idx == rx_len)
                        begin
                            // parity bit joins the running check
                            n.rx_par = s.rx_par ^ s.rxd_s;
                            n.rx_idx = s.rx_idx + 4'h1;
                        end
                        else
                        begin
                            // first stop bit ends the character
                            n.rx_st = RX_IDLE;
                            n.rx_buf = s.rx_shift;
                            n.rx_ready = 1'b1;
                            if (s.rx_ready)
                            begin
                                n.overrun_flag = 1'b1;
                            end
                            if (!s.rxd_s)
                            begin
                                n.framing_fault = 1'b1;
                            end
                            if (s.mode[MODE_PARITY_ENABLE] && s.rx_par)
                            begin
                                n.parity_flag = 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
        // status byte built from the flag flops, pin flops and transmit buffer state
        status = 8'h00;
        status[ST_TRANSMIT_READY] = ~pend;
        status[ST_RECEIVE_READY] = s.rx_ready;
        status[ST_TRANSMITTER_EMPTY] = s.transmitter_empty;
        status[ST_PARITY_FLAG] = s.parity_flag;
        status[ST_OVERRUN] = s.overrun_flag;
        status[ST_FRAMING_FAULT] = s.framing_fault;
        status[ST_SYNC_DETECT] = s.sync_detect;
        status[ST_DATA_SET_READY] = ~s.dsr_s;
        // read data path, driven while the read strobe is low
        n.data_out = s.cd_s ? status : s.rx_buf;
        n.data_oe = rd_act;
        // pins
        n.transmit_ready = (n.req == s.ack_s) & ~s.cts_s & n.cmd[CMD_TRANSMIT_ENABLE];
        n.transmitter_empty = (n.req == s.ack_s) & ~s.busy_s & ~n.wait_busy;
        n.sync_detect = 1'b0;
        n.request_to_send_n = ~n.cmd[CMD_REQUEST_TO_SEND];
        n.terminal_ready_n = ~n.cmd[CMD_TERMINAL_READY];
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            s <= SYS_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    assign data_out = s.data_out;
    assign data_oe = s.data_oe;
    assign request_to_send_n = s.request_to_send_n;
    assign terminal_ready_n = s.terminal_ready_n;
    assign transmit_ready = s.transmit_ready;
    assign receive_ready = s.rx_ready;
    assign transmitter_empty = s.transmitter_empty;
    assign sync_detect = s.sync_detect;
endmodule : ures_top

`default_nettype wire

// ===== inc/ures_pkg.sv
package ures_pkg;
    // status byte bit positions
    localparam int ST_TRANSMIT_READY = 0;
    localparam int ST_RECEIVE_READY = 1;
    localparam int ST_TRANSMITTER_EMPTY = 2;
    localparam int ST_PARITY_FLAG = 3;
    localparam int ST_OVERRUN = 4;
    localparam int ST_FRAMING_FAULT = 5;
    localparam int ST_SYNC_DETECT = 6;
    localparam int ST_DATA_SET_READY = 7;
    // command byte bit positions
    localparam int CMD_TRANSMIT_ENABLE = 0;
    localparam int CMD_TERMINAL_READY = 1;
    localparam int CMD_RECEIVE_ENABLE = 2;
    localparam int CMD_SEND_BREAK = 3;
    localparam int CMD_CLEAR_FAULT_FLAGS = 4;
    localparam int CMD_REQUEST_TO_SEND = 5;
    localparam int CMD_SOFT_RESET = 6;
    // mode byte fields
    localparam int MODE_BAUD_LSB = 0;
    localparam int MODE_LEN_LSB = 2;
    localparam int MODE_PARITY_ENABLE = 4;
    localparam int MODE_PARITY_EVEN = 5;
    localparam int MODE_STOP_LSB = 6;
    localparam int MODE_SINGLE_SYNC = 7;
    localparam logic [1:0] BAUD_SYNC = 2'h0;
    localparam logic [1:0] BAUD_X1 = 2'h1;
    localparam logic [1:0] BAUD_X16 = 2'h2;
    localparam logic [1:0] STOP_TWO = 2'h3;
    // clock edges per bit minus one, and to mid start bit minus one
    localparam logic [5:0] DIV_X1 = 6'h00;
    localparam logic [5:0] DIV_X16 = 6'h0F;
    localparam logic [5:0] DIV_X64 = 6'h3F;
    localparam logic [5:0] HALF_X16 = 6'h07;
    localparam logic [5:0] HALF_X64 = 6'h1F;
    localparam logic [3:0] LEN_BASE = 4'h5;
    localparam int FRAME_W = 12;
    // configuration word passed to the link domain
    localparam int CFG_SYNC2_LSB = 0;
    localparam int CFG_SYNC1_LSB = 8;
    localparam int CFG_MODE_LSB = 16;
    localparam int CFG_BREAK = 24;
    localparam int CFG_TX_ENABLE = 25;
    localparam int CFG_RUN = 26;
    localparam int CFG_W = 27;

    typedef enum logic [2:0] {IS_MODE, IS_SYNC1, IS_SYNC2, IS_CMD, IS_RUN} ures_init_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ures_rx_e;

    typedef struct packed {
        logic [CFG_W-1:0] cfg_m, cfg_s;
        logic req_m, req_s, cts_m, cts_s;
        logic ack, busy, armed, sel2, txd;
        logic [FRAME_W-1:0] sh;
        logic [3:0] left;
        logic [5:0] div;
    } ures_link_s;

    typedef struct packed {
        logic cs_m, cs_s, rd_m, rd_s, wr_m, wr_s, cd_m, cd_s;
        logic [7:0] din_m, din_s;
        logic cts_m, cts_s, dsr_m, dsr_s, rxc_m, rxc_s, rxc_p, rxd_m, rxd_s;
        logic ack_m, ack_s, ack_p, busy_m, busy_s;
        logic rd_p, wr_p, wr_cd;
        logic [7:0] wr_data;
        ures_init_e init;
        logic run;
        logic [7:0] mode, sync1, sync2, cmd, tx_data;
        logic req, wait_busy;
        ures_rx_e rx_st;
        logic [5:0] rx_cnt;
        logic [3:0] rx_idx;
        logic [7:0] rx_shift, rx_buf;
        logic rx_par, rx_ready, parity_flag, overrun_flag, framing_fault;
        logic [7:0] data_out;
        logic data_oe, transmit_ready, transmitter_empty, sync_detect;
        logic request_to_send_n, terminal_ready_n;
    } ures_sys_s;

    localparam ures_link_s LINK_RESET = '{txd: 1'b1, default: '0};
    localparam ures_sys_s SYS_RESET = '{cs_m: 1'b1, cs_s: 1'b1, rd_m: 1'b1, rd_s: 1'b1,
        wr_m: 1'b1, wr_s: 1'b1, rxd_m: 1'b1, rxd_s: 1'b1, cts_m: 1'b1, cts_s: 1'b1,
        dsr_m: 1'b1, dsr_s: 1'b1, init: IS_MODE, rx_st: RX_IDLE, request_to_send_n: 1'b1,
        terminal_ready_n: 1'b1, transmitter_empty: 1'b1, default: '0};
endpackage : ures_pkg

// ===== tb/ures_checker.sv
`timescale 1ns/1ps
`default_nettype none
// pin checks on the cpu side of the controller
module ures_checker
    import ures_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic ctrl_data_sel,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic txd,
    input wire logic clear_to_send_n,
    input wire logic data_set_ready_n,
    input wire logic transmit_ready,
    input wire logic receive_ready,
    input wire logic transmitter_empty
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    // status read in progress
    wire logic st = !cs_n && !rd_n && ctrl_data_sel;
    a_read_drive:
    assert property ((!cs_n && !rd_n)[*5] |-> data_oe) else $error("bus not driven");
    a_read_release:
    assert property (rd_n[*5] |-> !data_oe) else $error("bus still driven");
    a_dsr_bit:
    assert property ((st && $stable(data_set_ready_n))[*6] |-> data_out[ST_DATA_SET_READY]
        != data_set_ready_n) else $error("dsr bit wrong");
    a_rx_mirror:
    assert property ((st && $stable(receive_ready))[*6] |-> data_out[ST_RECEIVE_READY]
        == receive_ready) else $error("rx ready bit differs");
    a_txbuf_bit:
    assert property ((st && transmit_ready)[*6] |-> data_out[ST_TRANSMIT_READY])
        else $error("buffer bit low");
    a_cts_gate:
    assert property (clear_to_send_n[*6] |-> !transmit_ready) else $error("tx ready no cts");
    a_reset_idle:
    assert property ($rose(rstn) |-> txd && transmitter_empty) else $error("not idle");
    a_rx_clear:
    assert property (receive_ready && !cs_n && !rd_n && !ctrl_data_sel |-> ##[1:6]
        !receive_ready) else $error("rx ready kept");
endmodule : ures_checker
bind ures_top ures_checker u_chk (.*);
`default_nettype wire

// ===== tb/ures_peer.sv
`timescale 1ns/1ps
`default_nettype none
// serial peer: free-running baud clocks, receive frames, transmit capture
module ures_peer
(
    output logic tx_bit_clock,
    output logic receive_bit_clock,
    output logic rxd,
    input wire logic txd
);
    logic txq[$]; // transmit line, one entry a bit, oldest first
    // both clocks at one baud rate, phase unrelated to the system clock
    initial
    begin
        {tx_bit_clock, rxd} = 2'h3;
        #17;
        forever #40 tx_bit_clock = ~tx_bit_clock;
    end
    initial
    begin
        receive_bit_clock = 1'h1;
        #33;
        forever #40 receive_bit_clock = ~receive_bit_clock;
    end
    // line settles after the falling edge, read on the rising one
    always @(posedge tx_bit_clock)
        txq.push_back(txd);
    // raw bits, bit zero first, then back to mark
    task automatic send(input logic [19:0] b, input int n);
        for (int i = 0; i < n; i++)
            @(negedge receive_bit_clock) rxd = b[i];
        @(negedge receive_bit_clock) rxd = 1'h1;
    endtask : send
endmodule : ures_peer
`default_nettype wire

// ===== tb/ures_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// cpu bus bench with a serial peer
module ures_top_tb_top;
    logic ref_clk, rstn, cs_n, rd_n, wr_n, sel, cts_n, dsr_n, tclk, rclk, txd, rxd, trdy, rrdy, te;
    logic rts, dtr, sd; // modem outputs and sync detect pin
    logic [7:0] din, dout, v;
    logic [23:0] p;
    int fails, num_checks, k;
    ures_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .ctrl_data_sel(sel), .data_in(din), .data_out(dout), .data_oe(), .tx_bit_clock(tclk),
        .txd(txd), .receive_bit_clock(rclk), .rxd(rxd), .clear_to_send_n(cts_n),
        .data_set_ready_n(dsr_n), .request_to_send_n(rts), .terminal_ready_n(dtr),
        .transmit_ready(trdy), .receive_ready(rrdy), .transmitter_empty(te), .sync_detect(sd));
    ures_peer u_peer (.tx_bit_clock(tclk), .receive_bit_clock(rclk), .rxd(rxd), .txd(txd));
    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic summarize;
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // cpu write, acted on at the strobe's rise
    task automatic wr(input logic c, input logic [7:0] d);
        @(posedge ref_clk);
        {cs_n, wr_n, sel, din} <= {2'h0, c, d};
        repeat (4) @(posedge ref_clk);
        wr_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
    endtask : wr
    // cpu read, data taken while the strobe is still low
    task automatic rd(input logic c);
        @(posedge ref_clk);
        {cs_n, rd_n, sel} <= {2'h0, c};
        repeat (6) @(posedge ref_clk);
        v = dout;
        {cs_n, rd_n} <= 2'h3;
        repeat (5) @(posedge ref_clk);
    endtask : rd
    // frames into the receiver, bounded wait for ready
    task automatic rx(input logic [19:0] b, input int n);
        u_peer.send(b, n);
        repeat (12) @(posedge ref_clk);
        for (k = 0; k < 300 && rrdy !== 1'h1; k++)
            @(posedge ref_clk);
        if (rrdy !== 1'h1)
        begin
            chk("rx ready", 1, rrdy);
            summarize();
        end
    endtask : rx
    initial
    begin
        {rstn, cs_n, rd_n, wr_n, sel, cts_n, dsr_n, din} <= {7'h3C, 8'h00};
        fails = 0;
        num_checks = 0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (4) @(posedge ref_clk);
        wr(1'h1, 8'hF9); // x1, seven bits, even parity, two stop
        wr(1'h1, 8'h15); // transmit and receive on, errors cleared
        chk("tx ready pin", 1, trdy);
        rd(1'h1);
        chk("status", 8'h85, v);
        {cts_n, dsr_n} <= 2'h3;
        repeat (6) @(posedge ref_clk);
        chk("tx ready pin", 0, trdy);
        rd(1'h1);
        chk("status", 8'h05, v);
        cts_n <= 1'h0;
        rx({10'h3B6, 10'h242}, 20);
        rd(1'h1);
        chk("status", 8'h17, v);
        rd(1'h0);
        chk("rx data", 8'h5B, v);
        chk("rx ready pin", 0, rrdy);
        rx(20'h000B6, 10); // bad parity, stop bit low
        rd(1'h1);
        chk("status", 8'h3F, v);
        wr(1'h1, 8'h37); // clear errors, modem outputs on
        chk("modem pins", 3'h0, {rts, dtr, sd});
        rd(1'h1);
        chk("status", 8'h07, v);
        wr(1'h1, 8'h3F);
        repeat (30) @(posedge ref_clk);
        u_peer.txq.delete();
        repeat (100) @(posedge ref_clk);
        chk("break line", 0, u_peer.txq.or());
        wr(1'h1, 8'h40);
        chk("tx empty pin", 1, te);
        chk("modem pins", 3'h6, {rts, dtr, sd});
        repeat (30) @(posedge ref_clk);
        u_peer.txq.delete();
        wr(1'h1, 8'h0C); // sync, eight bits, two sync characters
        wr(1'h1, 8'h16);
        wr(1'h1, 8'h35);
        wr(1'h1, 8'h01);
        repeat (100) @(posedge ref_clk);
        wr(1'h0, 8'h5A);
        chk("tx empty pin", 0, te);
        repeat (400) @(posedge ref_clk);
        chk("tx empty pin", 1, te);
        k = 0;
        while (k < u_peer.txq.size() && u_peer.txq[k] !== 1'h0)
            k++;
        for (int i = 0; i < 24; i++)
            p[i] = u_peer.txq[k + i];
        chk("sync stream", 24'h35165A, p);
        summarize();
    end
endmodule : ures_top_tb_top
`default_nettype wire
